// ---- hw/fspl_map.svh ----
// constants of the flash protection controller: command words, addresses, timing counts
`ifndef FSPL_MAP_SVH
`define FSPL_MAP_SVH
`define FSPL_ADDR_W        22
`define FSPL_DATA_W        16
`define FSPL_GRP_LSB       17
`define FSPL_GRP_W         5
`define FSPL_NGRP          32
`define FSPL_UNLK_A1       22'h00_0555
`define FSPL_UNLK_A2       22'h00_02AA
`define FSPL_UNLK_D1       16'h00AA
`define FSPL_UNLK_D2       16'h0055
`define FSPL_CMD_PROG      16'h00A0
`define FSPL_CMD_ERASE     16'h0080
`define FSPL_CMD_SERASE    16'h0030
`define FSPL_CMD_AUTOSEL   16'h0090
`define FSPL_CMD_REGION_IN 16'h0088
`define FSPL_CMD_REGION_EX 16'h0000
`define FSPL_CMD_RESET     16'h00F0
`define FSPL_CMD_PROT      16'h0060
`define FSPL_PROT_ADDR_LO  22'h00_0002
`define FSPL_UNPROT_ADDR_LO 22'h00_0042
`define FSPL_IND_ADDR      22'h00_0003
`define FSPL_IND_BIT       7
`define FSPL_REGION_WORDS  128
`define FSPL_SERIAL_LAST   22'h00_0007
`define FSPL_PROT_YES      8'h01
`define FSPL_PROT_NO       8'h00
`define FSPL_T_PULSE_NS    100
`define FSPL_T_PULSE_CYC   (((`FSPL_T_PULSE_NS) + 9) / 10)
`define FSPL_T_ACC_NS      90
`define FSPL_T_ACC_CYC     (((`FSPL_T_ACC_NS) + 9) / 10)
`endif

// ---- hw/fspl_pkg.sv ----
// types of the flash protection controller
package fspl_pkg;
   typedef enum logic [2:0] {
      FSPL_OP_READ,
      FSPL_OP_PROGRAM,
      FSPL_OP_ERASE,
      FSPL_OP_PROT_GROUP,
      FSPL_OP_UNPROT_ALL,
      FSPL_OP_REGION_IN,
      FSPL_OP_REGION_EX,
      FSPL_OP_QUERY
   } fspl_op_t;
   typedef enum logic [2:0] {
      FSPL_ST_IDLE,
      FSPL_ST_SETUP,
      FSPL_ST_STROBE,
      FSPL_ST_HOLD,
      FSPL_ST_NEXT,
      FSPL_ST_DONE
   } fspl_state_t;
endpackage

// ---- hw/fspl_seq_rom.sv ----
// step table of bus cycles for each controller operation, read data registered
`timescale 1ns/1ns
`include "fspl_map.svh"
module fspl_seq_rom (
   input  wire logic                    clk_i,
   input  wire logic                    ce_i,
   input  wire fspl_pkg::fspl_op_t      op_i,
   input  wire logic [2:0]              step_i,
   input  wire logic [`FSPL_ADDR_W-1:0] addr_i,
   input  wire logic [`FSPL_DATA_W-1:0] data_i,
   output logic                         wr_o,
   output logic                         last_o,
   output logic [`FSPL_ADDR_W-1:0]      addr_o,
   output logic [`FSPL_DATA_W-1:0]      data_o
);
   logic                    wr_d;
   logic                    last_d;
   logic [`FSPL_ADDR_W-1:0] addr_d;
   logic [`FSPL_DATA_W-1:0] data_d;
   logic [`FSPL_ADDR_W-1:0] grp_a;
   // every command but read, protect and unprotect is preceded by the two unlock writes so stray writes never act
   always_comb begin
      grp_a  = {addr_i[`FSPL_ADDR_W-1:`FSPL_GRP_LSB], {`FSPL_GRP_LSB{1'b0}}};
      wr_d   = 1'b1;
      last_d = 1'b0;
      addr_d = `FSPL_UNLK_A1;
      data_d = `FSPL_UNLK_D1;
      if (step_i == 3'd1) begin
         addr_d = `FSPL_UNLK_A2;
         data_d = `FSPL_UNLK_D2;
      end
      case (op_i)
         fspl_pkg::FSPL_OP_READ: begin
            wr_d   = 1'b0;
            last_d = 1'b1;
            addr_d = addr_i;
         end
         fspl_pkg::FSPL_OP_PROGRAM: begin // [R18]
            if (step_i == 3'd2) data_d = `FSPL_CMD_PROG;
            if (step_i == 3'd3) begin
               addr_d = addr_i;
               data_d = data_i;
               last_d = 1'b1;
            end
         end
         fspl_pkg::FSPL_OP_ERASE: begin // [R18]
            if (step_i == 3'd2) data_d = `FSPL_CMD_ERASE;
            // erase repeats the full unlock pair before the sector word [R18]
            if (step_i == 3'd4) begin
               addr_d = `FSPL_UNLK_A2;
               data_d = `FSPL_UNLK_D2;
            end
            if (step_i == 3'd5) begin
               addr_d = addr_i;
               data_d = `FSPL_CMD_SERASE;
               last_d = 1'b1;
            end
         end
         fspl_pkg::FSPL_OP_REGION_IN: begin
            if (step_i == 3'd2) begin
               data_d = `FSPL_CMD_REGION_IN;
               last_d = 1'b1;
            end
         end
         fspl_pkg::FSPL_OP_REGION_EX: begin // [R17]
            if (step_i == 3'd2) data_d = `FSPL_CMD_AUTOSEL;
            if (step_i == 3'd3) begin
               data_d = `FSPL_CMD_REGION_EX;
               last_d = 1'b1;
            end
         end
         fspl_pkg::FSPL_OP_PROT_GROUP: begin // [R4]
            addr_d = grp_a | `FSPL_PROT_ADDR_LO;
            data_d = `FSPL_CMD_PROT;
            if (step_i == 3'd1) begin
               wr_d   = 1'b0;
               last_d = 1'b1;
            end
         end
         // software must have protected every group before this op is issued [R5]
         fspl_pkg::FSPL_OP_UNPROT_ALL: begin // [R4] [R5]
            addr_d = `FSPL_UNPROT_ADDR_LO;
            data_d = `FSPL_CMD_PROT;
            if (step_i == 3'd1) begin
               wr_d   = 1'b0;
               last_d = 1'b1;
            end
         end
         fspl_pkg::FSPL_OP_QUERY: begin // [R22]
            if (step_i == 3'd2) data_d = `FSPL_CMD_AUTOSEL;
            if (step_i == 3'd3) begin
               wr_d   = 1'b0;
               addr_d = grp_a | {14'h0000, addr_i[7:0]};
            end
            if (step_i == 3'd4) data_d = `FSPL_CMD_RESET;
            if (step_i == 3'd4) last_d = 1'b1;
         end
         default: last_d = 1'b1;
      endcase
   end
   // registered lookup so the main sequencer sees stable pins one cycle later
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         wr_o   <= wr_d;
         last_o <= last_d;
         addr_o <= addr_d;
         data_o <= data_d;
      end
   end
endmodule

// ---- hw/fspl_ctrl.sv ----
// host controller driving the flash pins for protection and secured region operations
`timescale 1ns/1ns
`include "fspl_map.svh"
// Notes on behaviour
// (R1) device refuses program and erase inside a protected group
// (R2) protection applies to whole groups of four sectors
// (R3) group chosen by the five group select bits, 32 groups
// (R4) protect and unprotect use plain bus cycles with high voltage on reset
// (R5) host protects every unprotected group before the first unprotect write
// (R6) device ships with all groups unprotected
// (R7) reset at high voltage lets protected groups be programmed and erased
// (R8) removing high voltage restores earlier protection
// (R9) 128-word secured region, lock indicator on the indicator data bit
// (R10) indicator fixed: 1 factory locked, 0 customer lockable
// (R11) first eight region words carry the serial number field when factory locked
// (R12) after enter command first sector addresses reach the secured region
// (R13) power-up or hardware reset leaves secured region mode
// (R14) a protected secured region cannot be changed or unprotected
// (R15) unprotected region accepts all program methods
// (R16) region protect runs in region mode with reset high or high voltage
// (R17) host exits region mode before touching the normal array
// (R18) program and erase need unlock writes first
// (R19) below lockout threshold the device ignores writes
// (R20) write only when chip select and write strobe low, output drive high
// (R21) no command taken on strobe rise during power-up
// (R22) group status reads low byte 01h protected, 00h unprotected
// (R23) protection flags are non-volatile
module fspl_ctrl (
   input  wire logic                    CLOCK_I,
   input  wire logic                    SRST_I,
   input  wire logic                    CE_I,
   input  wire logic                    REQ_I,
   input  wire fspl_pkg::fspl_op_t      OP_I,
   input  wire logic [`FSPL_ADDR_W-1:0] ADDR_I,
   input  wire logic [`FSPL_DATA_W-1:0] WDATA_I,
   input  wire logic                    SUPPLY_OK_I,
   output logic                         BUSY_O,
   output logic                         DONE_O,
   output logic [`FSPL_DATA_W-1:0]      RDATA_O,
   output logic                         PROT_O,
   output logic                         IND_O,
   output logic                         HV_RESET_O,
   output logic                         FL_RESET_N_O,
   output logic                         FL_CS_N_O,
   output logic                         FL_WE_N_O,
   output logic                         FL_OE_N_O,
   output logic [`FSPL_ADDR_W-1:0]      FL_ADDR_O,
   output logic [`FSPL_DATA_W-1:0]      FL_DQ_O,
   output logic                         FL_DQ_OE_N_O,
   input  wire logic [`FSPL_DATA_W-1:0] FL_DQ_I
);
   localparam logic [3:0] PULSE_CYC = 4'(`FSPL_T_PULSE_CYC);
   localparam logic [3:0] ACC_CYC   = 4'(`FSPL_T_ACC_CYC);

   fspl_pkg::fspl_state_t   st_q, st_d;
   fspl_pkg::fspl_op_t      op_q, op_d;
   logic [2:0]              step_q, step_d;
   logic [3:0]              cnt_q, cnt_d;
   logic [`FSPL_ADDR_W-1:0] addr_q, addr_d;
   logic [`FSPL_DATA_W-1:0] wdat_q, wdat_d;
   logic                    busy_q, busy_d, done_q, done_d;
   logic [`FSPL_DATA_W-1:0] rdat_q, rdat_d;
   logic                    prot_q, prot_d, ind_q, ind_d, hv_q, hv_d;
   logic                    cs_q, cs_d, we_q, we_d, oe_q, oe_d, dqoe_q, dqoe_d;
   logic [`FSPL_ADDR_W-1:0] fa_q, fa_d;
   logic [`FSPL_DATA_W-1:0] fd_q, fd_d;
   logic [`FSPL_DATA_W-1:0] dq_s1_q, dq_s2_q;
   logic [1:0]              sup_q;
   logic                    rom_wr, rom_last;
   logic                    rst_n_q, rst_n_d;
   logic [3:0]              we_run_q, we_run_d;
   logic [`FSPL_ADDR_W-1:0] rom_addr;
   logic [`FSPL_DATA_W-1:0] rom_data;

   fspl_seq_rom u_rom (
      .clk_i  (CLOCK_I),
      .ce_i   (CE_I),
      .op_i   (op_q),
      .step_i (step_q),
      .addr_i (addr_q),
      .data_i (wdat_q),
      .wr_o   (rom_wr),
      .last_o (rom_last),
      .addr_o (rom_addr),
      .data_o (rom_data)
   );

   // pin inputs pass two flops; only the second stage is read
   always_ff @(posedge CLOCK_I) begin
      if (CE_I) begin
         dq_s1_q <= FL_DQ_I;
         dq_s2_q <= dq_s1_q;
         sup_q   <= {sup_q[0], SUPPLY_OK_I};
      end
   end

   // sequencer: setup loads the table, strobe holds the pin pulse, hold releases it
   always_comb begin
      st_d = st_q; op_d = op_q; step_d = step_q; cnt_d = cnt_q;
      addr_d = addr_q; wdat_d = wdat_q; busy_d = busy_q; done_d = 1'b0;
      rdat_d = rdat_q; prot_d = prot_q; ind_d = ind_q; hv_d = hv_q;
      cs_d = 1'b1; we_d = 1'b1; oe_d = 1'b1; dqoe_d = 1'b1;
      fa_d = fa_q; fd_d = fd_q;
      rst_n_d = 1'b1;
      case (st_q)
         fspl_pkg::FSPL_ST_IDLE: begin
            // requests wait while supply is low: the device ignores writes then [R19]
            if (REQ_I && sup_q[1]) begin
               op_d = OP_I; addr_d = ADDR_I; wdat_d = WDATA_I;
               step_d = 3'd0; busy_d = 1'b1; st_d = fspl_pkg::FSPL_ST_SETUP;
               // protect and unprotect need high voltage on the reset pin [R4]
               // region protect runs with it too, which is also allowed [R16]
               hv_d = (OP_I == fspl_pkg::FSPL_OP_PROT_GROUP) ||
                      (OP_I == fspl_pkg::FSPL_OP_UNPROT_ALL);
            end
         end
         fspl_pkg::FSPL_ST_SETUP: begin
            cnt_d = 4'd0;
            st_d  = fspl_pkg::FSPL_ST_STROBE;
         end
         fspl_pkg::FSPL_ST_STROBE: begin
            fa_d = rom_addr; fd_d = rom_data;
            cs_d = 1'b0;
            // write needs cs and we low with oe high; read the reverse [R20]
            we_d   = ~rom_wr;
            oe_d   = rom_wr;
            dqoe_d = ~rom_wr;
            cnt_d  = cnt_q + 4'd1;
            if (cnt_q == (rom_wr ? PULSE_CYC : ACC_CYC)) begin
               cs_d = 1'b1; we_d = 1'b1; oe_d = 1'b1; dqoe_d = 1'b1;
               st_d = fspl_pkg::FSPL_ST_HOLD;
               if (!rom_wr) begin
                  rdat_d = dq_s2_q;
                  // low byte 01h marks a protected group [R22]
                  if (op_q == fspl_pkg::FSPL_OP_QUERY || op_q == fspl_pkg::FSPL_OP_PROT_GROUP)
                     prot_d = (dq_s2_q[7:0] == `FSPL_PROT_YES);
                  ind_d = dq_s2_q[`FSPL_IND_BIT]; // [R10]
               end
            end
         end
         fspl_pkg::FSPL_ST_HOLD: begin
            st_d = rom_last ? fspl_pkg::FSPL_ST_DONE : fspl_pkg::FSPL_ST_NEXT;
         end
         fspl_pkg::FSPL_ST_NEXT: begin
            step_d = step_q + 3'd1;
            st_d   = fspl_pkg::FSPL_ST_SETUP;
         end
         fspl_pkg::FSPL_ST_DONE: begin
            // dropping high voltage restores earlier protection [R8]
            hv_d = 1'b0; busy_d = 1'b0; done_d = 1'b1;
            st_d = fspl_pkg::FSPL_ST_IDLE;
         end
         default: st_d = fspl_pkg::FSPL_ST_IDLE;
      endcase
   end

   // pins idle deasserted from reset so nothing is strobed at power-up [R21]
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         st_q <= fspl_pkg::FSPL_ST_IDLE; op_q <= fspl_pkg::FSPL_OP_READ;
         step_q <= 3'd0; cnt_q <= 4'd0; addr_q <= '0; wdat_q <= '0;
         busy_q <= 1'b0; done_q <= 1'b0; rdat_q <= '0;
         prot_q <= 1'b0; ind_q <= 1'b0; hv_q <= 1'b0;
         cs_q <= 1'b1; we_q <= 1'b1; oe_q <= 1'b1; dqoe_q <= 1'b1;
         fa_q <= '0; fd_q <= '0;
         rst_n_q <= 1'b0; // device reset pin follows ours, leaving region mode [R13]
      end else if (CE_I) begin
         st_q <= st_d; op_q <= op_d; step_q <= step_d; cnt_q <= cnt_d;
         addr_q <= addr_d; wdat_q <= wdat_d;
         busy_q <= busy_d; done_q <= done_d; rdat_q <= rdat_d;
         prot_q <= prot_d; ind_q <= ind_d; hv_q <= hv_d;
         cs_q <= cs_d; we_q <= we_d; oe_q <= oe_d; dqoe_q <= dqoe_d;
         fa_q <= fa_d; fd_q <= fd_d;
         rst_n_q <= rst_n_d;
      end
   end

   assign BUSY_O       = busy_q;
   assign DONE_O       = done_q;
   assign RDATA_O      = rdat_q;
   assign PROT_O       = prot_q;
   assign IND_O        = ind_q;
   assign HV_RESET_O   = hv_q;
   assign FL_RESET_N_O = rst_n_q;
   assign FL_CS_N_O    = cs_q;
   assign FL_WE_N_O    = we_q;
   assign FL_OE_N_O    = oe_q;
   assign FL_ADDR_O    = fa_q;
   assign FL_DQ_O      = fd_q;
   assign FL_DQ_OE_N_O = dqoe_q;

   // a write strobe never overlaps output drive [R20]
   a_strobe_excl: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // [R20]
      !(!FL_WE_N_O && !FL_OE_N_O))
      else $error("write and output strobes overlap");
   // a write strobe always comes with chip select [R20]
   a_we_with_cs: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // [R20]
      !FL_WE_N_O |-> !FL_CS_N_O)
      else $error("write strobe without chip select");
   // high voltage only while an operation is busy [R4]
   a_hv_op_only: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // [R4]
      HV_RESET_O |-> BUSY_O)
      else $error("high voltage outside an operation");
   // done is a single pulse and clears busy [R8]
   a_done_clears: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // [R8]
      DONE_O |-> (!BUSY_O && !HV_RESET_O) ##1 !DONE_O)
      else $error("done pulse malformed");
   // helper run length of the write strobe; saturates so long pulses never wrap
   always_comb begin
      we_run_d = 4'd0;
      if (!FL_WE_N_O && we_run_q != 4'hF) we_run_d = we_run_q + 4'd1;
      else if (!FL_WE_N_O) we_run_d = we_run_q;
   end
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) we_run_q <= 4'd0;
      else if (CE_I) we_run_q <= we_run_d;
   end
   // write pulse lasts the full pulse width [R18]
   a_we_width: assert property (@(posedge CLOCK_I) disable iff (SRST_I || !CE_I) // [R18]
      $rose(FL_WE_N_O) |-> (we_run_q >= PULSE_CYC))
      else $error("write pulse too short");
   // no strobe while idle [R21]
   a_idle_quiet: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // [R21]
      !BUSY_O && !DONE_O |-> FL_CS_N_O)
      else $error("chip select while idle");
   // data driven only while writing [R20]
   a_dq_drive: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // [R20]
      !FL_DQ_OE_N_O |-> !FL_WE_N_O)
      else $error("data driven outside write");
   // request is refused when supply is low [R19]
   a_low_supply: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // [R19]
      (!BUSY_O && !sup_q[1] && CE_I) |=> !BUSY_O)
      else $error("operation started below lockout");
endmodule

// ---- verification/fspl_flash_model.sv ----
// behavioural flash device: group protection, secured region, write inhibits
`timescale 1ns/1ns
module fspl_flash_model #(
   parameter bit FACTORY_LOCK = 1'b0
) (
   input  wire logic        reset_n_i,
   input  wire logic        hv_i,
   input  wire logic        vcc_ok_i,
   input  wire logic        slow_i,
   input  wire logic        cs_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic [21:0] addr_i,
   input  wire logic [15:0] dq_i,
   output logic [15:0]      dq_o,
   output logic             order_err_o
);
   logic [15:0] mem [logic [21:0]];
   logic [15:0] rmem [128];
   logic [21:0] ks [$];
   logic [31:0] prot_q = '0; // not touched by any reset
   logic [21:0] wa;
   logic [15:0] wd;
   logic [15:0] rd_val = '0;
   logic [15:0] last_q = '0;
   int          cyc = 0;
   bit          prog = 0, ers = 0, auto_m = 0, region = 0, armed = 0, seen_idle = 0, drive = 0;
   bit          rlock = FACTORY_LOCK;
   // region contents; factory parts carry a made-up serial in the first eight words
   initial begin
      order_err_o = 1'b0;
      for (int i = 0; i < 128; i++) rmem[i] = (FACTORY_LOCK && i < 8) ? 16'h5A00 + i : 16'hFFFF;
   end
   function automatic logic [15:0] read_word(input logic [21:0] a);
      if (auto_m && a[7:0] == 8'h02) return {15'h0000, prot_q[a[21:17]]};
      if (auto_m && a[7:0] == 8'h03) return {8'h00, FACTORY_LOCK, 7'h18};
      if (region && a[21:15] == 7'h00) return rmem[a[6:0]];
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   task automatic program_word(input logic [21:0] a, input logic [15:0] d);
      if (region && a[21:15] == 7'h00) begin
         if (!rlock) rmem[a[6:0]] = rmem[a[6:0]] & d;
      end else if (!prot_q[a[21:17]] || hv_i) begin
         mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & d;
      end
   endtask
   // command decoder; any broken unlock cycle drops back to read mode
   task automatic take(input logic [21:0] a, input logic [15:0] d);
      if (prog) begin
         prog = 0;
         program_word(a, d);
      end else if (d[7:0] == 8'h60 && (hv_i || region)) begin
         if (a[7:0] == 8'h42 && hv_i) begin
            if (prot_q != '1) order_err_o = 1'b1;
            prot_q = '0;
         end else if (a[7:0] == 8'h02) begin
            if (region) rlock = 1'b1;
            else prot_q[a[21:17]] = 1'b1;
         end
         cyc = 0;
      end else if (d == 16'h00F0) begin
         auto_m = 0;
         cyc = 0;
      end else if (auto_m && d == 16'h0000) begin
         auto_m = 0;
         region = 0;
      end else if (cyc == 0) cyc = (a[10:0] == 11'h555 && d == 16'h00AA) ? 1 : 0;
      else if (cyc == 1) cyc = (a[10:0] == 11'h2AA && d == 16'h0055) ? 2 : 0;
      else begin
         cyc = 0;
         case (d)
            16'h00A0: prog = 1;
            16'h0080: ers = 1;
            16'h0090: auto_m = 1;
            16'h0088: region = 1;
            16'h0000: region = 0;
            16'h0030: if (ers && (!prot_q[a[21:17]] || hv_i)) begin
               ks.delete();
               foreach (mem[k]) if (k[21:15] == a[21:15]) ks.push_back(k);
               foreach (ks[i]) mem.delete(ks[i]);
            end
            default: cyc = 0;
         endcase
         if (d != 16'h0080) ers = 0;
      end
   endtask
   // write committed when the strobe pair ends; nothing taken before strobes idle once
   always @(cs_n_i or we_n_i or oe_n_i or addr_i or dq_i) begin
      if (cs_n_i && we_n_i) seen_idle = 1'b1;
      if (!cs_n_i && !we_n_i && oe_n_i && vcc_ok_i && seen_idle) begin
         armed = 1;
         wa = addr_i;
         wd = dq_i;
      end else if (armed) begin
         armed = 0;
         if (vcc_ok_i) take(wa, wd);
      end
   end
   // low supply or reset pin returns to read mode and leaves the region
   always @(negedge vcc_ok_i or negedge reset_n_i) begin
      cyc = 0;
      prog = 0;
      auto_m = 0;
      armed = 0;
      region = 0;
   end
   // read path with selectable access time; released bus shows the inverted last word
   always @(negedge oe_n_i) begin
      #(slow_i ? 40 : 5);
      if (!cs_n_i && !oe_n_i) begin
         rd_val = read_word(addr_i);
         drive = 1;
      end
   end
   always @(posedge oe_n_i or posedge cs_n_i) begin
      if (drive) last_q = rd_val;
      drive = 0;
   end
   assign dq_o = drive ? rd_val : ~last_q;
endmodule

// ---- verification/testbench.sv ----
// self-checking bench: controller against the behavioural flash device
`timescale 1ns/1ns
module testbench;
   logic clk, srst, ce, req, supply_ok, slow, busy, done, prot, ind, hv, rst_n;
   logic cs_n, we_n, oe_n, dq_oe_n, order_err;
   fspl_pkg::fspl_op_t op;
   logic [21:0] addr, fl_addr, a5;
   logic [15:0] wdata, rdata, fl_dq, dq_in, d0, d1, d2;
   logic [17:0] exp_q [$];
   int          mismatches = 0;
   int          compares = 0;
   fspl_ctrl u_dut (.CLOCK_I(clk), .SRST_I(srst), .CE_I(ce), .REQ_I(req), .OP_I(op),
      .ADDR_I(addr), .WDATA_I(wdata), .SUPPLY_OK_I(supply_ok), .BUSY_O(busy), .DONE_O(done),
      .RDATA_O(rdata), .PROT_O(prot), .IND_O(ind), .HV_RESET_O(hv), .FL_RESET_N_O(rst_n),
      .FL_CS_N_O(cs_n), .FL_WE_N_O(we_n), .FL_OE_N_O(oe_n), .FL_ADDR_O(fl_addr),
      .FL_DQ_O(fl_dq), .FL_DQ_OE_N_O(dq_oe_n), .FL_DQ_I(dq_in));
   fspl_flash_model u_flash (.reset_n_i(rst_n), .hv_i(hv), .vcc_ok_i(supply_ok), .slow_i(slow),
      .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fl_addr), .dq_i(fl_dq),
      .dq_o(dq_in), .order_err_o(order_err));
   always #5 clk = ~clk;
   task automatic test_done;
      if (mismatches == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("Error %0t %s", $time, msg);
      end
   endtask
   function automatic logic [17:0] xr(input logic [15:0] v);
      return {2'h1, v};
   endfunction
   function automatic logic [17:0] xp(input logic b);
      return {2'h2, 15'h0000, b};
   endfunction
   function automatic logic [17:0] xi(input logic b);
      return {2'h3, 15'h0000, b};
   endfunction
   // one request held until busy shows, then a bounded wait for completion
   task automatic do_op(input fspl_pkg::fspl_op_t o, input logic [21:0] a, input logic [17:0] e);
      int n;
      n = 0;
      exp_q.push_back(e);
      op = o;
      addr = a;
      wdata = d0;
      slow = 1'($urandom_range(0, 1));
      req = 1'b1;
      while (busy !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
      req = 1'b0;
      while (busy !== 1'b0 && n < 3000) begin @(posedge clk); #1; n++; end
      if (n >= 3000) chk(1'b0, "operation never completed");
   endtask
   // result watcher: oldest note against each completion
   always @(posedge clk) begin
      if (done === 1'b1) begin
         if (exp_q.size() == 0) chk(1'b0, "completion without request");
         else if (exp_q[0][17:16] == 2'h1) chk(rdata === exp_q[0][15:0], "read data wrong");
         else if (exp_q[0][17:16] == 2'h2) chk(prot === exp_q[0][0], "group status wrong");
         else if (exp_q[0][17:16] == 2'h3) chk(ind === exp_q[0][0], "indicator wrong");
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
   end
   initial begin
      #400000;
      chk(1'b0, "watchdog expired");
      test_done;
   end
   initial begin
      clk = 0; srst = 1; ce = 1; req = 0; supply_ok = 1; slow = 0;
      op = fspl_pkg::FSPL_OP_READ; addr = '0; wdata = '0;
      void'($urandom(42));
      d0 = 16'($urandom); d1 = 16'($urandom); d2 = 16'($urandom) & 16'h7FFF;
      a5 = {5'h05, 9'($urandom), 8'h02};
      repeat (2) @(posedge clk);
      #1 srst = 0;
      do_op(fspl_pkg::FSPL_OP_QUERY, 22'h00_0002, xp(1'b0));
      do_op(fspl_pkg::FSPL_OP_QUERY, 22'h00_0003, xi(1'b0));
      do_op(fspl_pkg::FSPL_OP_QUERY, 22'h3E_0002, xp(1'b0));
      do_op(fspl_pkg::FSPL_OP_PROGRAM, a5, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_READ, a5, xr(d0));
      do_op(fspl_pkg::FSPL_OP_PROT_GROUP, a5, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_QUERY, a5, xp(1'b1));
      do_op(fspl_pkg::FSPL_OP_QUERY, a5 ^ 22'h06_0000, xp(1'b0));
      d0 = ~d0;
      do_op(fspl_pkg::FSPL_OP_PROGRAM, a5 ^ 22'h01_8000, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_READ, a5 ^ 22'h01_8000, xr(16'hFFFF));
      do_op(fspl_pkg::FSPL_OP_ERASE, a5, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_READ, a5, xr(~d0));
      for (int g = 0; g < 32; g++) do_op(fspl_pkg::FSPL_OP_PROT_GROUP, {5'(g), 17'h0_0000}, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_UNPROT_ALL, a5, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_QUERY, a5, xp(1'b0));
      chk(order_err === 1'b0, "unprotect before all groups protected");
      do_op(fspl_pkg::FSPL_OP_ERASE, a5, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_READ, a5, xr(16'hFFFF));
      d0 = d1;
      do_op(fspl_pkg::FSPL_OP_PROGRAM, 22'h00_0000, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_REGION_IN, 22'h00_0000, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_READ, 22'h00_0000, xr(16'hFFFF));
      d0 = d2;
      do_op(fspl_pkg::FSPL_OP_PROGRAM, 22'h00_0008, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_READ, 22'h00_0008, xr(d2));
      do_op(fspl_pkg::FSPL_OP_PROT_GROUP, 22'h00_0000, 18'h0_0000);
      d0 = 16'h0000;
      do_op(fspl_pkg::FSPL_OP_PROGRAM, 22'h00_0008, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_READ, 22'h00_0008, xr(d2));
      do_op(fspl_pkg::FSPL_OP_REGION_EX, 22'h00_0000, 18'h0_0000);
      do_op(fspl_pkg::FSPL_OP_READ, 22'h00_0000, xr(d1));
      do_op(fspl_pkg::FSPL_OP_REGION_IN, 22'h00_0000, 18'h0_0000);
      srst = 1;
      repeat (2) @(posedge clk);
      #1 srst = 0;
      do_op(fspl_pkg::FSPL_OP_READ, 22'h00_0000, xr(d1));
      supply_ok = 0;
      repeat (3) @(posedge clk);
      #1 op = fspl_pkg::FSPL_OP_PROGRAM;
      addr = a5;
      req = 1;
      repeat (30) @(posedge clk);
      #1 chk(busy === 1'b0 && cs_n === 1'b1, "request taken under low supply");
      req = 0;
      supply_ok = 1;
      repeat (3) @(posedge clk);
      #1 do_op(fspl_pkg::FSPL_OP_READ, a5, xr(16'hFFFF));
      repeat (2) @(posedge clk);
      #1 chk(exp_q.size() == 0, "results missing");
      test_done;
   end
endmodule
